// >>> src/dacc_regs.vh
`ifndef DACC_REGS_VH
`define DACC_REGS_VH

// ----------------------------------------
// register numbers and control cell addresses
// ----------------------------------------
`define DACC_REG_SPDIF_CS 8'h56
`define DACC_REG_PROG_SEL 8'h6B
`define DACC_CELL_ENC 11'h7F0
`define DACC_CELL_IOCTL 11'h7F1
`define DACC_CELL_APP_SEL 11'h7F6
`define DACC_CELL_APP_RUN 11'h7F7

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define DACC_RST_SPDIF_CS 20'h00000
`define DACC_RST_PROG_SEL 20'h00000
`define DACC_RST_ENC 20'hA0264
`define DACC_RST_APP 20'h00000
`define DACC_RST_IOCTL 20'h00000
`define DACC_ENC_QUAL_HI 19
`define DACC_ENC_QUAL_LO 17
`define DACC_QUAL_DEFAULT 3'h5
`define DACC_IOCTL_VALIDATE 0
`define DACC_APP_ENC_L3 6
`define DACC_APP_DEC_L3 3
`define DACC_APP_DEC_L2 2
`define DACC_APP_TOP 1
`define DACC_APP_OS 0
`define DACC_APP_MASK 20'h0004F

// ----------------------------------------
// telegram command codes (upper nibble of first byte; the short code sits in the lower nibble)
// ----------------------------------------
`define DACC_CMD_RD_REG 4'hA
`define DACC_CMD_WR_REG 4'hB
`define DACC_CMD_RD_D0 4'hC
`define DACC_CMD_RD_D1 4'hD
`define DACC_CMD_WR_D0 4'hE
`define DACC_CMD_WR_D1 4'hF
`define DACC_CMD_SHORT 4'h4

// ----------------------------------------
// timing and limits
// ----------------------------------------
`define DACC_MAX_KBPS 9'h0C0
`define DACC_APP_SETTLE_CYC 4'hA

`endif

// >>> src/dacc_app_engine.v
`include "dacc_regs.vh"
`default_nettype none

module dacc_app_engine (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // selection and pending settings
    input wire sel_wr,
    input wire [19:0] app_select,
    input wire [19:0] enc_pending,
    input wire validate,
    // loop status and applied settings
    output reg [19:0] app_running_reg,
    output reg [19:0] enc_active_reg,
    output reg validate_ack_reg
);

    localparam [3:0] SETTLE_CYC = `DACC_APP_SETTLE_CYC;
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_SWITCH = 2'h1;
    reg [1:0] state_reg;
    reg [3:0] settle_reg;
    reg [19:0] target_reg;

    // --------------------------------------------
    // loop switching and settings take-over
    // --------------------------------------------
    // a new selection drops the running cell first, so a host polling for
    // zero never sees a stale loop while the firmware changes over
    always @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_RUN;
            settle_reg <= 4'h0;
            target_reg <= `DACC_RST_APP;
            app_running_reg <= `DACC_RST_APP;
            enc_active_reg <= `DACC_RST_ENC;
            validate_ack_reg <= 1'b0;
        end else begin
            validate_ack_reg <= 1'b0;
            if (sel_wr) begin
                app_running_reg <= 20'h00000;
                target_reg <= app_select & `DACC_APP_MASK;
                settle_reg <= SETTLE_CYC;
                state_reg <= ST_SWITCH;
                if (app_select != 20'h00000) begin
                    enc_active_reg <= enc_pending;
                end
            end else begin
                case (state_reg)
                    ST_RUN: begin
                        // skip the edge where the clear is still landing, so a
                        // late unvalidated write is never taken over twice
                        if (validate && !validate_ack_reg) begin
                            enc_active_reg <= enc_pending;
                            validate_ack_reg <= 1'b1;
                        end
                    end
                    ST_SWITCH: begin
                        if (settle_reg <= 4'h1) begin
                            app_running_reg <= target_reg;
                            state_reg <= ST_RUN;
                        end else begin
                            settle_reg <= settle_reg - 4'h1;
                        end
                    end
                    default: begin
                        state_reg <= ST_RUN;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// >>> src/dacc_ctrl_cells.v
`include "dacc_regs.vh"
`default_nettype none

module dacc_ctrl_cells #(
    parameter CS_WIDTH = 16
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // control telegram byte stream
    input wire tg_start,
    input wire tg_stop,
    input wire tg_byte_valid,
    input wire [7:0] tg_byte,
    // read answer byte stream
    input wire rd_req,
    output reg rd_byte_valid_reg,
    output reg [7:0] rd_byte_reg,
    // incoming digital audio channel status
    input wire cs_valid,
    input wire [CS_WIDTH-1:0] cs_bits,
    // encoder rate path
    input wire [8:0] enc_rate_req,
    output reg [8:0] enc_rate_reg,
    output wire [2:0] enc_quality,
    output wire [19:0] enc_settings_active,
    // program ram configuration
    output wire [19:0] prog_ram_cfg,
    // loop status
    input wire detected_layer3,
    output wire os_loop_active,
    output wire top_loop_active,
    output wire enc_l3_active,
    output wire dec_l3_active,
    output wire dec_l2_active
);

    localparam [1:0] P_IDLE = 2'h0;
    localparam [1:0] P_HEAD = 2'h1;
    localparam [1:0] P_DATA = 2'h2;
    localparam [1:0] P_DROP = 2'h3;

    reg [1:0] pstate_reg;
    reg [2:0] idx_reg;
    reg [1:0] sub_reg;
    reg [3:0] code_reg;
    reg short_reg;
    reg [7:0] reg_num_reg;
    reg [15:0] cnt_reg;
    reg [10:0] addr_reg;
    reg [19:0] data_reg;

    reg [19:0] spdif_in_status_word_reg;
    reg [19:0] ram_program_select_reg;
    reg [19:0] encode_settings_reg;
    reg [19:0] io_control_reg;
    reg [19:0] application_select_reg;

    reg rd_is_reg_reg;
    reg rd_is_d1_reg;
    reg rd_short_reg;
    reg [10:0] rd_addr_reg;
    reg [15:0] rd_left_reg;
    reg [1:0] rd_sub_reg;

    wire [19:0] application_running;
    wire validate_ack;
    wire byte_in;
    wire reg_wr;
    wire mem_wr;
    wire [19:0] wr_value;
    wire sel_wr;
    wire [19:0] rd_word;

    // --------------------------------------------
    // read decode, shared by register and cell reads
    // --------------------------------------------
    // anything outside the defined set reads as zero
    function [19:0] dacc_read;
        input is_reg;
        input is_d1;
        input [10:0] addr;
        begin
            dacc_read = 20'h00000;
            if (is_reg) begin
                if (addr[7:0] == `DACC_REG_SPDIF_CS) begin
                    dacc_read = spdif_in_status_word_reg;
                end else if (addr[7:0] == `DACC_REG_PROG_SEL) begin
                    dacc_read = ram_program_select_reg;
                end
            end else if (!is_d1) begin
                case (addr)
                    `DACC_CELL_ENC: dacc_read = encode_settings_reg;
                    `DACC_CELL_IOCTL: dacc_read = io_control_reg;
                    `DACC_CELL_APP_SEL: dacc_read = application_select_reg;
                    `DACC_CELL_APP_RUN: dacc_read = application_running;
                    default: dacc_read = 20'h00000;
                endcase
            end
        end
    endfunction

    // --------------------------------------------
    // write strobes decoded from the current byte
    // --------------------------------------------
    assign byte_in = tg_byte_valid && !tg_stop;
    assign reg_wr = byte_in && pstate_reg == P_HEAD && idx_reg == 3'h3 &&
        code_reg == `DACC_CMD_WR_REG;
    assign mem_wr = byte_in && pstate_reg == P_DATA && sub_reg == 2'h3 &&
        code_reg == `DACC_CMD_WR_D0 && cnt_reg != 16'h0000;
    // short writes clear the four upper bits of the cell
    assign wr_value = {short_reg && !reg_wr ? 4'h0 : data_reg[19:16],
        data_reg[15:8], tg_byte};
    assign sel_wr = mem_wr && addr_reg == `DACC_CELL_APP_SEL;

    // --------------------------------------------
    // telegram parser
    // --------------------------------------------
    // only one telegram is decoded at a time; a stop mid-telegram drops
    // whatever was half received, so no partial word is ever written
    always @(posedge core_clk) begin
        if (reset) begin
            pstate_reg <= P_IDLE;
            idx_reg <= 3'h0;
            sub_reg <= 2'h0;
            code_reg <= 4'h0;
            short_reg <= 1'b0;
            reg_num_reg <= 8'h00;
            cnt_reg <= 16'h0000;
            addr_reg <= 11'h000;
            data_reg <= 20'h00000;
        end else if (tg_stop) begin
            pstate_reg <= P_IDLE;
        end else if (tg_start) begin
            pstate_reg <= P_HEAD;
            idx_reg <= 3'h0;
        end else if (byte_in) begin
            case (pstate_reg)
                P_HEAD: begin
                    idx_reg <= idx_reg + 3'h1;
                    case (idx_reg)
                        3'h0: begin
                            code_reg <= tg_byte[7:4];
                            short_reg <= tg_byte[3:0] == `DACC_CMD_SHORT;
                            reg_num_reg[7:4] <= tg_byte[3:0];
                            if (tg_byte[7:4] < `DACC_CMD_RD_REG) begin
                                pstate_reg <= P_DROP;
                            end
                        end
                        3'h1: begin
                            reg_num_reg[3:0] <= tg_byte[7:4];
                            data_reg[19:16] <= tg_byte[3:0];
                            if (code_reg == `DACC_CMD_RD_REG) begin
                                pstate_reg <= P_DROP;
                            end
                        end
                        3'h2: begin
                            data_reg[15:8] <= tg_byte;
                            cnt_reg[15:8] <= tg_byte;
                        end
                        3'h3: begin
                            cnt_reg[7:0] <= tg_byte;
                            if (code_reg == `DACC_CMD_WR_REG) begin
                                pstate_reg <= P_DROP;
                            end
                        end
                        3'h4: begin
                            addr_reg[10:8] <= tg_byte[2:0];
                        end
                        default: begin
                            addr_reg[7:0] <= tg_byte;
                            sub_reg <= short_reg ? 2'h2 : 2'h0;
                            if (code_reg == `DACC_CMD_WR_D0 ||
                                code_reg == `DACC_CMD_WR_D1) begin
                                pstate_reg <= P_DATA;
                            end else begin
                                pstate_reg <= P_DROP;
                            end
                        end
                    endcase
                end
                P_DATA: begin
                    if (sub_reg == 2'h1) begin
                        data_reg[19:16] <= tg_byte[3:0];
                    end
                    if (sub_reg == 2'h2) begin
                        data_reg[15:8] <= tg_byte;
                    end
                    if (sub_reg == 2'h3) begin
                        sub_reg <= short_reg ? 2'h2 : 2'h0;
                        addr_reg <= addr_reg + 11'h001;
                        if (cnt_reg != 16'h0000) begin
                            cnt_reg <= cnt_reg - 16'h0001;
                        end
                    end else begin
                        sub_reg <= sub_reg + 2'h1;
                    end
                end
                default: begin
                    pstate_reg <= pstate_reg;
                end
            endcase
        end
    end

    // --------------------------------------------
    // host registers and control cells
    // --------------------------------------------
    always @(posedge core_clk) begin
        if (reset) begin
            spdif_in_status_word_reg <= `DACC_RST_SPDIF_CS;
            ram_program_select_reg <= `DACC_RST_PROG_SEL;
            encode_settings_reg <= `DACC_RST_ENC;
            io_control_reg <= `DACC_RST_IOCTL;
            application_select_reg <= `DACC_RST_APP;
        end else begin
            // status bits follow the line, never the host
            if (cs_valid) begin
                spdif_in_status_word_reg <= {{(20-CS_WIDTH){1'b0}}, cs_bits};
            end
            if (reg_wr && reg_num_reg == `DACC_REG_PROG_SEL) begin
                ram_program_select_reg <= wr_value;
            end
            // writes to the status register or unknown numbers fall through
            // no decode path exists for them, so a stray write changes nothing
            if (validate_ack) begin
                io_control_reg[`DACC_IOCTL_VALIDATE] <= 1'b0;
            end
            if (mem_wr) begin
                case (addr_reg)
                    `DACC_CELL_ENC: encode_settings_reg <= wr_value;
                    `DACC_CELL_IOCTL: io_control_reg <= wr_value;
                    `DACC_CELL_APP_SEL: application_select_reg <= wr_value;
                    default: application_select_reg <= application_select_reg;
                endcase
            end
        end
    end

    // --------------------------------------------
    // read answer stream
    // --------------------------------------------
    // bytes are produced one per request; a request with nothing armed
    // answers a zero byte so the host never waits on a silent port
    assign rd_word = dacc_read(rd_is_reg_reg, rd_is_d1_reg, rd_addr_reg);

    always @(posedge core_clk) begin
        if (reset) begin
            rd_is_reg_reg <= 1'b0;
            rd_is_d1_reg <= 1'b0;
            rd_short_reg <= 1'b0;
            rd_addr_reg <= 11'h000;
            rd_left_reg <= 16'h0000;
            rd_sub_reg <= 2'h0;
            rd_byte_valid_reg <= 1'b0;
            rd_byte_reg <= 8'h00;
        end else begin
            rd_byte_valid_reg <= rd_req;
            if (byte_in && pstate_reg == P_HEAD && idx_reg == 3'h1 &&
                code_reg == `DACC_CMD_RD_REG) begin
                rd_is_reg_reg <= 1'b1;
                rd_short_reg <= 1'b0;
                rd_addr_reg <= {3'h0, reg_num_reg[7:4], tg_byte[7:4]};
                rd_left_reg <= 16'h0001;
                rd_sub_reg <= 2'h0;
            end else if (byte_in && pstate_reg == P_HEAD && idx_reg == 3'h5 &&
                (code_reg == `DACC_CMD_RD_D0 || code_reg == `DACC_CMD_RD_D1)) begin
                rd_is_reg_reg <= 1'b0;
                rd_is_d1_reg <= code_reg == `DACC_CMD_RD_D1;
                rd_short_reg <= short_reg;
                rd_addr_reg <= {addr_reg[10:8], tg_byte};
                rd_left_reg <= cnt_reg;
                rd_sub_reg <= short_reg ? 2'h2 : 2'h0;
            end else if (rd_req) begin
                rd_byte_reg <= 8'h00;
                if (rd_left_reg != 16'h0000) begin
                    case (rd_sub_reg)
                        2'h0: rd_byte_reg <= 8'h00;
                        2'h1: rd_byte_reg <= {4'h0, rd_word[19:16]};
                        2'h2: rd_byte_reg <= rd_word[15:8];
                        default: rd_byte_reg <= rd_word[7:0];
                    endcase
                    if (rd_sub_reg == 2'h3) begin
                        rd_sub_reg <= rd_short_reg ? 2'h2 : 2'h0;
                        rd_addr_reg <= rd_addr_reg + 11'h001;
                        rd_left_reg <= rd_left_reg - 16'h0001;
                    end else begin
                        rd_sub_reg <= rd_sub_reg + 2'h1;
                    end
                end
            end
        end
    end

    // --------------------------------------------
    // application loop engine
    // --------------------------------------------
    dacc_app_engine u_engine (
        .core_clk(core_clk),
        .reset(reset),
        .sel_wr(sel_wr),
        .app_select(wr_value),
        .enc_pending(encode_settings_reg),
        .validate(io_control_reg[`DACC_IOCTL_VALIDATE]),
        .app_running_reg(application_running),
        .enc_active_reg(enc_settings_active),
        .validate_ack_reg(validate_ack)
    );

    // --------------------------------------------
    // encoder rate limit
    // --------------------------------------------
    // the cap holds at every quality level, so a bad request cannot
    // push the stream past what a decoder must accept
    always @(posedge core_clk) begin
        if (reset) begin
            enc_rate_reg <= 9'h000;
        end else if (enc_rate_req > `DACC_MAX_KBPS) begin
            enc_rate_reg <= `DACC_MAX_KBPS;
        end else begin
            enc_rate_reg <= enc_rate_req;
        end
    end

    // --------------------------------------------
    // loop and configuration outputs
    // --------------------------------------------
    assign enc_quality = enc_settings_active[`DACC_ENC_QUAL_HI:`DACC_ENC_QUAL_LO];
    assign prog_ram_cfg = ram_program_select_reg;
    assign os_loop_active = application_running[`DACC_APP_OS];
    assign top_loop_active = application_running[`DACC_APP_TOP];
    assign enc_l3_active = application_running[`DACC_APP_ENC_L3];
    // with both decoders selected the detected layer picks one
    assign dec_l3_active = application_running[`DACC_APP_DEC_L3] &&
        (!application_running[`DACC_APP_DEC_L2] || detected_layer3);
    assign dec_l2_active = application_running[`DACC_APP_DEC_L2] &&
        (!application_running[`DACC_APP_DEC_L3] || !detected_layer3);

endmodule

`default_nettype wire

// >>> testbench/dacc_ctrl_checker.sv
`default_nettype none
module dacc_ctrl_checker #(
    parameter CS_WIDTH = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // host side
    input wire logic tg_byte_valid,
    input wire logic rd_req,
    input wire logic [8:0] enc_rate_req,
    // device side
    input wire logic rd_byte_valid_reg,
    input wire logic [7:0] rd_byte_reg,
    input wire logic [8:0] enc_rate_reg,
    input wire logic [2:0] enc_quality,
    input wire logic [19:0] enc_settings_active,
    input wire logic [19:0] prog_ram_cfg,
    input wire logic os_loop_active,
    input wire logic top_loop_active,
    input wire logic enc_l3_active,
    input wire logic dec_l3_active,
    input wire logic dec_l2_active
);
    timeunit 1ns / 1ps;
    // ----------------------------------------
    // helper counter and assertions
    // ----------------------------------------
    logic [5:0] idle_reg;
    logic [5:0] idle_next;
    // cycles since last telegram byte; saturates so a long idle never wraps
    always_comb idle_next = tg_byte_valid ? 6'h00 : idle_reg + {5'h00, idle_reg != 6'h3F};
    always_ff @(posedge core_clk) idle_reg <= reset ? 6'h3F : idle_next;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_answer;
        ##1 rd_byte_valid_reg;
    endsequence
    rd_answer_a: assert property (rd_req |-> s_answer)
        else $error("no answer byte");
    rd_quiet_a: assert property (!rd_req |=> !rd_byte_valid_reg)
        else $error("answer byte without pull");
    rd_hold_a: assert property (!rd_req |=> $stable(rd_byte_reg))
        else $error("answer byte moved");
    rate_cap_a: assert property (1'b1 |=> enc_rate_reg ==
        ($past(enc_rate_req) > 9'h0C0 ? 9'h0C0 : $past(enc_rate_req)))
        else $error("encoder rate not capped");
    quality_map_a: assert property (enc_quality == enc_settings_active[19:17])
        else $error("quality field mismatch");
    reset_value_a: assert property ($fell(reset) |->
        prog_ram_cfg == 20'h00000 && enc_settings_active == 20'hA0264)
        else $error("wrong value after reset");
    dec_excl_a: assert property (!(dec_l3_active && dec_l2_active))
        else $error("both decoder loops active");
    loop_rise_a: assert property ($rose(os_loop_active) || $rose(top_loop_active) ||
        $rose(enc_l3_active) |-> idle_reg inside {[6'h06:6'h10]})
        else $error("loop start off selection");
    cfg_quiet_a: assert property (!$past(tg_byte_valid) |-> $stable(prog_ram_cfg))
        else $error("program select moved");
    enc_apply_a: assert property ($changed(enc_settings_active) |-> idle_reg <= 6'h01)
        else $error("settings applied late");
endmodule
bind dacc_ctrl_cells dacc_ctrl_checker #(.CS_WIDTH(CS_WIDTH)) chk_i (.core_clk(core_clk),
    .reset(reset), .tg_byte_valid(tg_byte_valid), .rd_req(rd_req),
    .enc_rate_req(enc_rate_req), .rd_byte_valid_reg(rd_byte_valid_reg),
    .rd_byte_reg(rd_byte_reg), .enc_rate_reg(enc_rate_reg), .enc_quality(enc_quality),
    .enc_settings_active(enc_settings_active), .prog_ram_cfg(prog_ram_cfg),
    .os_loop_active(os_loop_active), .top_loop_active(top_loop_active),
    .enc_l3_active(enc_l3_active), .dec_l3_active(dec_l3_active),
    .dec_l2_active(dec_l2_active));
`default_nettype wire

// >>> testbench/dacc_host_model.sv
`default_nettype none
module dacc_host_model (
    // clock
    input wire logic core_clk,
    // telegram stream
    output logic tg_start,
    output logic tg_stop,
    output logic tg_byte_valid,
    output logic [7:0] tg_byte,
    // answer stream
    output logic rd_req,
    input wire logic rd_byte_valid_reg,
    input wire logic [7:0] rd_byte_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // host telegram engine
    // ----------------------------------------
    logic [31:0] rx_word;
    logic rx_bad;
    // idle bus at time zero
    initial begin
        tg_start = 1'b0;
        tg_stop = 1'b0;
        tg_byte_valid = 1'b0;
        tg_byte = 8'h00;
        rd_req = 1'b0;
    end
    // whole telegram: start, bytes, stop; only defined places are ever addressed
    task automatic send(input logic [7:0] q[$]);
        @(posedge core_clk) #1 tg_start = 1'b1;
        foreach (q[i]) begin
            @(posedge core_clk) #1 tg_start = 1'b0;
            tg_byte_valid = 1'b1;
            tg_byte = q[i];
        end
        @(posedge core_clk) #1 tg_byte_valid = 1'b0;
        tg_byte = ~tg_byte; // released data never shows the stale byte
        tg_stop = 1'b1;
        @(posedge core_clk) #1 tg_stop = 1'b0;
    endtask
    // pull n answer bytes, each checked for its valid strobe one cycle on
    task automatic pull(input int n);
        rx_word = 32'h00000000;
        rx_bad = 1'b0;
        repeat (n) begin
            @(posedge core_clk) #1 rd_req = 1'b1;
            @(posedge core_clk) #1 rd_req = 1'b0;
            if (rd_byte_valid_reg !== 1'b1) rx_bad = 1'b1;
            rx_word = {rx_word[23:0], rd_byte_reg};
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/dsp_application_control_cells_tb.sv
`default_nettype none
module dsp_application_control_cells_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // bench signals and helpers
    // ----------------------------------------
    logic core_clk, reset, cs_valid, detected_layer3;
    logic [15:0] cs_bits;
    logic [8:0] enc_rate_req, enc_rate_reg;
    wire tg_start, tg_stop, tg_byte_valid, rd_req;
    wire [7:0] tg_byte;
    logic rd_byte_valid_reg, os_loop_active, top_loop_active;
    logic enc_l3_active, dec_l3_active, dec_l2_active;
    logic [7:0] rd_byte_reg;
    logic [2:0] enc_quality;
    logic [19:0] enc_settings_active, prog_ram_cfg;
    integer n_mismatch, tests_run;
    wire [19:0] run_v = {13'h0000, enc_l3_active, 2'h0, dec_l3_active, dec_l2_active,
        top_loop_active, os_loop_active};
    dacc_ctrl_cells #(.CS_WIDTH(16)) uut (.core_clk(core_clk), .reset(reset),
        .tg_start(tg_start), .tg_stop(tg_stop), .tg_byte_valid(tg_byte_valid),
        .tg_byte(tg_byte), .rd_req(rd_req), .rd_byte_valid_reg(rd_byte_valid_reg),
        .rd_byte_reg(rd_byte_reg), .cs_valid(cs_valid), .cs_bits(cs_bits),
        .enc_rate_req(enc_rate_req), .enc_rate_reg(enc_rate_reg), .enc_quality(enc_quality),
        .enc_settings_active(enc_settings_active), .prog_ram_cfg(prog_ram_cfg),
        .detected_layer3(detected_layer3), .os_loop_active(os_loop_active),
        .top_loop_active(top_loop_active), .enc_l3_active(enc_l3_active),
        .dec_l3_active(dec_l3_active), .dec_l2_active(dec_l2_active));
    dacc_host_model host (.core_clk(core_clk), .tg_start(tg_start), .tg_stop(tg_stop),
        .tg_byte_valid(tg_byte_valid), .tg_byte(tg_byte), .rd_req(rd_req),
        .rd_byte_valid_reg(rd_byte_valid_reg), .rd_byte_reg(rd_byte_reg));
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] r, input logic [19:0] d);
        host.send('{{4'hB, r[7:4]}, {r[3:0], d[19:16]}, d[15:8], d[7:0]});
    endtask
    task automatic rreg(input logic [7:0] r);
        host.send('{{4'hA, r[7:4]}, {r[3:0], 4'h0}});
        host.pull(4);
    endtask
    task automatic wcell(input logic [10:0] a, input logic [19:0] d);
        host.send('{8'hE0, 8'h00, 8'h00, 8'h01, {5'h00, a[10:8]}, a[7:0], 8'h00,
            {4'h0, d[19:16]}, d[15:8], d[7:0]});
    endtask
    task automatic rcell(input logic [10:0] a);
        host.send('{8'hC0, 8'h00, 8'h00, 8'h01, {5'h00, a[10:8]}, a[7:0]});
        host.pull(4);
    endtask
    // bounded wait on the loop outputs; running out ends the run
    task automatic wait_run(input logic [19:0] want);
        int k;
        k = 0;
        while (run_v !== want && k < 40) begin
            @(posedge core_clk) #1;
            k++;
        end
        chk(32'(run_v), 32'(want));
        if (k == 40) finish_test();
    endtask
    task automatic rate(input logic [8:0] req, input logic [8:0] exp);
        enc_rate_req = req;
        @(posedge core_clk) #1;
        chk(32'(enc_rate_reg), 32'(exp));
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(32'(prog_ram_cfg), 32'h0);
        chk(32'(enc_settings_active), 32'hA0264);
        chk(32'(enc_quality), 32'h5);
        chk(32'(run_v), 32'h0);
        $display("test reset done");
    endtask
    // read-only status must ignore host writes
    task automatic t_regs();
        wreg(8'h6B, 20'h81234);
        chk(32'(prog_ram_cfg), 32'h81234);
        rreg(8'h6B);
        chk(host.rx_word, 32'h00081234);
        cs_bits = 16'hBEEF;
        cs_valid = 1'b1;
        @(posedge core_clk) #1 cs_valid = 1'b0;
        wreg(8'h56, 20'h12345);
        rreg(8'h56);
        chk(host.rx_word, 32'h0000BEEF);
        chk(32'(host.rx_bad), 32'h0);
        wreg(8'h6B, 20'h00000);
        $display("test registers done");
    endtask
    task automatic t_app();
        wcell(11'h7F6, 20'h00000);
        wait_run(20'h00000);
        wcell(11'h7F0, 20'hE0264);
        chk(32'(enc_settings_active), 32'hA0264);
        detected_layer3 = 1'b1;
        wcell(11'h7F6, 20'h0004C);
        wait_run(20'h00048);
        chk(32'(enc_settings_active), 32'hE0264);
        chk(32'(enc_quality), 32'h7);
        rcell(11'h7F7);
        chk(host.rx_word, 32'h0000004C);
        detected_layer3 = 1'b0;
        @(posedge core_clk) #1;
        chk(32'(run_v), 32'h44);
        wcell(11'h7F6, 20'h00000);
        wait_run(20'h00000);
        wcell(11'h7F6, 20'h00043);
        wait_run(20'h00043);
        repeat (20) @(posedge core_clk);
        chk(32'(run_v), 32'h43);
        $display("test application done");
    endtask
    // settings held back until the validate bit is set
    task automatic t_valid();
        host.send('{8'hE4, 8'h00, 8'h00, 8'h01, 8'h07, 8'hF0, 8'h02, 8'h64});
        chk(32'(enc_settings_active), 32'hE0264);
        wcell(11'h7F1, 20'h00001);
        repeat (3) @(posedge core_clk);
        chk(32'(enc_settings_active), 32'h00264);
        chk(32'(enc_quality), 32'h0);
        rcell(11'h7F1);
        chk(host.rx_word, 32'h0);
        $display("test validate done");
    endtask
    task automatic t_rate();
        rate(9'h12C, 9'h0C0);
        rate(9'h0C1, 9'h0C0);
        rate(9'h0C0, 9'h0C0);
        rate(9'h064, 9'h064);
        $display("test rate done");
    endtask
    // main sequence
    initial begin
        reset = 1'b1;
        cs_valid = 1'b0;
        cs_bits = 16'h0000;
        enc_rate_req = 9'h000;
        detected_layer3 = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        t_reset();
        t_regs();
        t_app();
        t_valid();
        t_rate();
        finish_test();
    end
endmodule
`default_nettype wire
